// *** stpatt_ctrl.sv ***
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "stpatt_defs.svh"
module stpatt_ctrl
  import stpatt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output stpatt_pkg::stpatt_pins_s pins,
  input wire logic serial_out_pin
);
  import stpatt_pkg::*;
  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  logic [1:0] mode_q;
  logic long_q;
  stpatt_word_t word_q;
  logic go_q;
  logic busy;
  logic [7:0] echo_q;
  logic so_s1_q;
  logic so_s2_q;
  logic wr_fire;
  logic aw_ok;
  assign aw_ok = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = aw_ok;
  assign s_axi_wready = aw_ok;
  assign wr_fire = aw_ok;
  assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q <= `STPATT_MODE_RST;
      long_q <= `STPATT_LONG_RST;
      word_q <= `STPATT_WORD_RST;
      go_q <= 1'b0;
    end
    else
    begin
      go_q <= 1'b0;
      if (wr_fire && s_axi_wstrb[0])
      begin
        if (s_axi_awaddr == `STPATT_CTRL_OFF && !busy)
        begin
          mode_q <= s_axi_wdata[`STPATT_CTRL_MODE_HI:`STPATT_CTRL_MODE_LO];
          long_q <= s_axi_wdata[`STPATT_CTRL_LONG_BIT];
          go_q <= s_axi_wdata[`STPATT_CTRL_GO_BIT] && !busy;
        end
        else if (s_axi_awaddr == `STPATT_WORD_OFF)
          word_q <= s_axi_wdata[5:0];
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr == `STPATT_CTRL_OFF || s_axi_awaddr == `STPATT_WORD_OFF)
        ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        `STPATT_CTRL_OFF: s_axi_rdata <= {29'h0, long_q, mode_q};
        `STPATT_WORD_OFF: s_axi_rdata <= {26'h0, word_q};
        `STPATT_STAT_OFF: s_axi_rdata <= {23'h0, echo_q, busy};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  // ----------------------------------------
  // Pin sequencer
  // ----------------------------------------
  stpatt_state_e st_q;
  logic [7:0] half_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic strobe_q;
  logic sclk_q;
  logic sdat_q;
  stpatt_word_t par_q;
  logic half_end;
  assign half_end = (half_q == 8'(`STPATT_HALF_CYC - 1));
  assign busy = (st_q != STPATT_IDLE);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      half_q <= 8'h00;
    else if (st_q == STPATT_IDLE || half_end)
      half_q <= 8'h00;
    else
      half_q <= half_q + 8'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= STPATT_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      strobe_q <= 1'b0;
      sclk_q <= 1'b0;
      sdat_q <= 1'b0;
      par_q <= `STPATT_WORD_RST;
    end
    else
    begin
      unique case (st_q)
        STPATT_IDLE:
        begin
          sclk_q <= 1'b0;
          strobe_q <= (mode_q == STPATT_MODE_DIRECT);
          if (mode_q == STPATT_MODE_DIRECT)
            par_q <= word_q;
          if (go_q && mode_q == STPATT_MODE_SERIAL)
          begin
            sh_q <= {2'b00, word_q};
            bit_q <= long_q ? 4'(`STPATT_LONG_W) : 4'(`STPATT_WORD_W);
            st_q <= STPATT_SHIFT_LO;
          end
          else if (go_q && mode_q == STPATT_MODE_LATCHED)
          begin
            par_q <= word_q;
            st_q <= STPATT_SETUP;
          end
        end
        STPATT_SHIFT_LO:
        begin
          sclk_q <= 1'b0;
          strobe_q <= 1'b0;
          sdat_q <= long_q ? sh_q[7] : sh_q[5];
          if (half_end)
            st_q <= STPATT_SHIFT_HI;
        end
        STPATT_SHIFT_HI:
        begin
          sclk_q <= 1'b1;
          if (half_end)
          begin
            sh_q <= {sh_q[6:0], 1'b0};
            bit_q <= bit_q - 4'h1;
            st_q <= (bit_q == 4'h1) ? STPATT_SETUP : STPATT_SHIFT_LO;
          end
        end
        STPATT_SETUP:
        begin
          sclk_q <= 1'b0;
          if (half_end)
            st_q <= STPATT_STROBE;
        end
        STPATT_STROBE:
        begin
          strobe_q <= 1'b1;
          if (half_end)
            st_q <= STPATT_DONE;
        end
        STPATT_DONE:
        begin
          strobe_q <= 1'b0;
          if (half_end)
            st_q <= STPATT_IDLE;
        end
        default: st_q <= STPATT_IDLE;
      endcase
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      so_s1_q <= 1'b0;
      so_s2_q <= 1'b0;
      echo_q <= 8'h00;
    end
    else
    begin
      so_s1_q <= serial_out_pin;
      so_s2_q <= so_s1_q;
      if (st_q == STPATT_SHIFT_HI && half_end)
        echo_q <= {echo_q[6:0], so_s2_q};
    end
  end
  always_comb
  begin
    pins.latch_strobe = strobe_q;
    pins.interface_select = (mode_q == STPATT_MODE_SERIAL);
    if (mode_q == STPATT_MODE_SERIAL)
      pins.data_bits = {sclk_q, sdat_q, 4'h0};
    else
      pins.data_bits = par_q;
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_shift_low;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == STPATT_SHIFT_HI) |-> !strobe_q;
  endproperty
  a_shift_low: assert property (p_shift_low) else $error("strobe high while shifting");
  property p_strobe_after;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == STPATT_STROBE && $past(st_q) == STPATT_SETUP) |=> strobe_q;
  endproperty
  a_strobe_after: assert property (p_strobe_after) else $error("no strobe pulse");
  property p_direct;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == STPATT_IDLE && mode_q == STPATT_MODE_DIRECT) |=> strobe_q;
  endproperty
  a_direct: assert property (p_direct) else $error("direct strobe low");
  property p_select;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == STPATT_SHIFT_LO || st_q == STPATT_SHIFT_HI) |-> pins.interface_select;
  endproperty
  a_select: assert property (p_select) else $error("bad select");
  property p_clk_data;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(pins.data_bits[5]) && pins.interface_select) |-> $stable(pins.data_bits[4]);
  endproperty
  a_clk_data: assert property (p_clk_data) else $error("data moved on clock rise");
  property p_mask;
    @(posedge aclk) disable iff (!aresetn)
    (pins.interface_select && pins.latch_strobe) |-> !pins.data_bits[5];
  endproperty
  a_mask: assert property (p_mask) else $error("serial clock high under strobe");
  property p_latch_data;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(pins.latch_strobe) && mode_q == STPATT_MODE_LATCHED) |-> $stable(pins.data_bits);
  endproperty
  a_latch_data: assert property (p_latch_data) else $error("data moved at strobe");
endmodule

// *** stpatt_defs.svh ***
`ifndef STPATT_DEFS_SVH
`define STPATT_DEFS_SVH
// ----------------------------------------
// Register map (AXI4-Lite byte offsets)
// ----------------------------------------
`define STPATT_CTRL_OFF 4'h0
`define STPATT_WORD_OFF 4'h4
`define STPATT_STAT_OFF 4'h8
// CTRL fields
`define STPATT_CTRL_MODE_LO 0
`define STPATT_CTRL_MODE_HI 1
`define STPATT_CTRL_LONG_BIT 2
`define STPATT_CTRL_GO_BIT 3
// STAT fields
`define STPATT_STAT_BUSY_BIT 0
// Reset values
`define STPATT_WORD_RST 6'h3F
`define STPATT_MODE_RST 2'h0
`define STPATT_LONG_RST 1'b1
// ----------------------------------------
// Timing
// ----------------------------------------
`define STPATT_CLK_MHZ 125
`define STPATT_HALF_NS 40
`define STPATT_HALF_CYC ((`STPATT_HALF_NS * `STPATT_CLK_MHZ + 999) / 1000)
`define STPATT_WORD_W 6
`define STPATT_LONG_W 8
`endif

// *** stpatt_pkg.sv ***
package stpatt_pkg;
  typedef enum logic [1:0]
  {
    STPATT_MODE_SERIAL = 2'b00,
    STPATT_MODE_LATCHED = 2'b01,
    STPATT_MODE_DIRECT = 2'b10
  } stpatt_mode_e;
  typedef enum logic [2:0]
  {
    STPATT_IDLE = 3'b000,
    STPATT_SHIFT_LO = 3'b001,
    STPATT_SHIFT_HI = 3'b010,
    STPATT_STROBE = 3'b011,
    STPATT_SETUP = 3'b100,
    STPATT_DONE = 3'b101
  } stpatt_state_e;
  // Pins driven toward the attenuator
  typedef struct packed
  {
    logic latch_strobe;
    logic interface_select;
    logic [5:0] data_bits;
  } stpatt_pins_s;
  typedef logic [5:0] stpatt_word_t;
endpackage

// *** stpatt_dev.sv ***
`timescale 1ns/1ps
module stpatt_dev (
  input stpatt_pkg::stpatt_pins_s pins,
  output logic serial_out_pin,
  output stpatt_pkg::stpatt_word_t att_q
);
  import stpatt_pkg::*;
  // ----------------------------------------
  // Attenuator behaviour
  // ----------------------------------------
  // Powers up at maximum
  stpatt_word_t att_r = 6'h3F;
  logic [7:0] sh_q = 8'h00;
  logic clk_prev = 1'b0;
  logic le_prev = 1'b0;
  assign att_q = att_r;
  assign serial_out_pin = sh_q[7];
  // One process owns all state so edges and levels never race
  always @(pins)
  begin
    // Shift on clock rise, masked by strobe
    if (pins.interface_select && !pins.latch_strobe && pins.data_bits[5] === 1'b1 && !clk_prev)
      sh_q = {sh_q[6:0], pins.data_bits[4]};
    if (pins.interface_select && pins.latch_strobe === 1'b1 && !le_prev)
      att_r = sh_q[5:0];
    if (!pins.interface_select && pins.latch_strobe)
      att_r = pins.data_bits;
    clk_prev = (pins.data_bits[5] === 1'b1);
    le_prev = (pins.latch_strobe === 1'b1);
  end
endmodule

// *** stpatt_tb.sv ***
`timescale 1ns/1ps
`include "stpatt_defs.svh"
module tb;
  import stpatt_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sout;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d, w, prev;
  logic [1:0] bresp, rresp, r;
  stpatt_pins_s pins;
  stpatt_word_t att;
  stpatt_mode_e mt [4] = '{STPATT_MODE_SERIAL, STPATT_MODE_SERIAL,
    STPATT_MODE_LATCHED, STPATT_MODE_DIRECT};
  int error_cnt, tests_run, cyc, seed;
  int echo_m, nb;
  // Link model: serial out shows the bit shifted seven clocks before the current one
  int lnk[$] = '{0, 0, 0, 0, 0, 0, 0};
  stpatt_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pins(pins), .serial_out_pin(sout));
  stpatt_dev u_dev (.pins(pins), .serial_out_pin(sout), .att_q(att));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Handshakes are judged on values as they stood at the rising edge; bready and rready stay high
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic b;
    b = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    while (!b)
    begin
      @(posedge aclk);
      b = bvalid;
      rs = bresp;
      if (awvalid && awready)
        awvalid <= 0;
      if (wvalid && wready)
        wvalid <= 0;
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic b;
    b = 0;
    araddr <= a;
    arvalid <= 1;
    while (!b)
    begin
      @(posedge aclk);
      b = rvalid;
      v = rdata;
      rs = rresp;
      if (arvalid && arready)
        arvalid <= 0;
    end
  endtask
  initial
  begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    aresetn = 0;
    seed = 94749;
    echo_m = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    bready <= 1;
    rready <= 1;
    @(posedge aclk);
    rd(`STPATT_WORD_OFF, d, r);
    check("word_reset", d, 32'h3F);
    check("att_reset", att, 32'h3F);
    prev = 32'h3F;
    for (int i = 0; i < 4; i++)
    begin
      w = $random(seed) & 32'h3F;
      wr(`STPATT_WORD_OFF, w, r);
      check("att_hold", att, prev);
      wr(`STPATT_CTRL_OFF, {28'h0, 1'b1, i == 0, mt[i]}, r);
      if (mt[i] == STPATT_MODE_SERIAL)
      begin
        nb = (i == 0) ? 8 : 6;
        for (int k = nb - 1; k >= 0; k--)
        begin
          lnk.push_back(w[k]);
          echo_m = ((echo_m << 1) | lnk.pop_front()) & 255;
        end
      end
      repeat (4) @(posedge aclk);
      d = 1;
      while (d[0])
        rd(`STPATT_STAT_OFF, d, r);
      check("att_load", att, w);
      if (mt[i] == STPATT_MODE_SERIAL)
        check("echo", d[8:1], echo_m);
      check("strobe", pins.latch_strobe, mt[i] == STPATT_MODE_DIRECT);
      check("select", pins.interface_select, mt[i] == STPATT_MODE_SERIAL);
      prev = w;
    end
    w = $random(seed) & 32'h3F;
    wr(`STPATT_WORD_OFF, w, r);
    repeat (3) @(posedge aclk);
    check("direct_follow", att, w);
    // A cleared byte strobe must leave the word alone
    wstrb <= 4'h0;
    wr(`STPATT_WORD_OFF, ~w, r);
    wstrb <= 4'hF;
    rd(`STPATT_WORD_OFF, d, r);
    check("strobe_off", d, w);
    check("att_kept", att, w);
    wr(4'hC, 32'h1, r);
    check("unmapped_wr", r, 2'h2);
    rd(4'hC, d, r);
    check("unmapped_rd", d, 32'h0);
    check("unmapped_rresp", r, 2'h2);
    print_verdict();
  end
endmodule
